//--- verilog/dmip_ctrl.sv
// Dual-mode interrupt priority controller, top level
// Contract
// - Interrupt, restart, system call enter privileged mode
// - User-enabled peripherals request only the lower levels
// - User source at level 3 requests level 2
// - Four protection sources always at level 3
// - Same level ranked in fixed source order
// - Acknowledge clears violation and external requests
// - Watchdog request held until control write
// - Periodic request cleared by global status read
// - Unit status read clears timer/decoder/capture requests
// - Slave data access or status write clears
// - Serial receive cleared by data reads
// - Serial transmit cleared by data/status writes
// - Mode restore rotates stack right two
// - Mode detect in user mode flags violation; the code flags it only with dual mode on
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dmip_map.svh"
module dmip_ctrl #(
	parameter int unsigned PERIOD_CYCLES = `DMIP_PERIOD_CYCLES // Periodic interval
) (
	input wire logic mclk, // Clock, 20 MHz
	input wire logic rst_b, // Async reset, low
	input wire logic [15:0] busAddr, // I/O address
	input wire logic [7:0] busWdata, // Write data
	input wire logic busWr, // Write strobe
	input wire logic busRd, // Read strobe
	output logic [7:0] busRdata, // Read data, next cycle
	input wire logic evtStackLimit, // Stack limit violation
	input wire logic evtWriteProt, // Write protect violation
	input wire logic evtSecWatchdog, // Secondary watchdog timeout
	input wire logic evtExt1, // External 1 event
	input wire logic evtExt0, // External 0 event
	input wire logic evtQuad, // Quadrature decoder
	input wire logic evtTimerB, // Timer B
	input wire logic evtTimerA, // Timer A
	input wire logic evtCapture, // Input capture
	input wire logic evtPwm, // PWM
	input wire logic evtSlaveRx, // Slave port, data to read
	input wire logic evtSlaveTx, // Slave port, room to write
	input wire logic [5:0] evtSerRx, // Serial E,F,A,B,C,D receive
	input wire logic [5:0] evtSerTx, // Serial E,F,A,B,C,D transmit
	input wire logic [1:0] cpuLevel, // Core priority level
	input wire logic intAck, // Core takes presented request
	input wire logic restartInstr, // Restart instruction
	input wire logic sysCallInstr, // System call instruction
	input wire logic setUserInstr, // Set-user instruction
	input wire logic modeRestoreInstr, // Mode restore instruction
	input wire logic modeDetectInstr, // Mode detect instruction
	output logic irqReq, // Request to core
	output dmip_pkg::dmip_level_t irqLevel, // Requested level
	output dmip_pkg::dmip_src_t irqSrc, // Requesting source
	output logic userMode, // Core in unprivileged mode
	output logic [7:0] modeStack // Mode stack contents
);
	logic [`DMIP_NSINGLE-1:0] flag_reg, flag_next;
	logic [`DMIP_NSINGLE-1:0] evtSet, clrSingle;
	logic [`DMIP_NSINGLE-1:0] ackHit, ackClr;
	logic [`DMIP_NDUPLEX-1:0] rxFlag_reg, rxFlag_next;
	logic [`DMIP_NDUPLEX-1:0] txFlag_reg, txFlag_next;
	logic [`DMIP_NDUPLEX-1:0] rxClr, txClr;
	logic [`DMIP_NSRC-1:0] srcReq;
	logic [2*`DMIP_NSRC-1:0] effLvl;
	logic [2*`DMIP_NPROG-1:0] lvlCfg_reg, lvlCfg_next;
	logic [`DMIP_NPROG-1:0] usrCfg_reg, usrCfg_next;
	logic dualEn_reg, dualEn_next;
	logic [13:0] perCnt_reg, perCnt_next;
	logic perTick_reg, perTick_next;
	logic irqReq_reg, irqReq_next;
	dmip_pkg::dmip_level_t irqLevel_reg, irqLevel_next;
	dmip_pkg::dmip_src_t irqSrc_reg, irqSrc_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] readVal, modeStackQ;
	logic takeIrq, enterPriv, modeViolSet, selFound;
	dmip_pkg::dmip_level_t selLevel;
	dmip_pkg::dmip_src_t selSrc;

	// Core handshake and mode events
	assign takeIrq = intAck && irqReq_reg;
	assign enterPriv = takeIrq || restartInstr || sysCallInstr;
	// only user mode with dual mode on
	assign modeViolSet = modeDetectInstr && dualEn_reg && modeStackQ[0];

	dmip_mode_stack u_stack (
		.mclk(mclk),
		.rst_b(rst_b),
		.enter(enterPriv),
		.setUser(setUserInstr),
		.restore(modeRestoreInstr),
		.modeStack(modeStackQ)
	);

	// Periodic tick divider
	always_comb begin
		perTick_next = 1'b0;
		perCnt_next = perCnt_reg + 14'h0001;
		if (perCnt_reg == 14'(PERIOD_CYCLES - 1)) begin
			perCnt_next = 14'h0000;
			perTick_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			perCnt_reg <= 14'h0000;
			perTick_reg <= 1'b0;
		end else begin
			perCnt_reg <= perCnt_next;
			perTick_reg <= perTick_next;
		end
	end

	// Event sets for single-flag sources
	assign evtSet = {evtPwm, evtCapture, evtTimerA, evtTimerB, evtQuad, perTick_reg,
		evtExt0, evtExt1, evtSecWatchdog, evtWriteProt, evtStackLimit, modeViolSet};

	// Acknowledge decode of the presented source
	assign ackHit = takeIrq ? 12'h001 << irqSrc_reg : 12'h000;
	assign ackClr = ackHit & `DMIP_ACK_CLR_MASK;

	// Clear decode for single-flag sources
	always_comb begin
		clrSingle = ackClr;
		clrSingle[3] = busWr && busAddr == `DMIP_ADDR_WDOG;
		clrSingle[6] = busRd && busAddr == `DMIP_ADDR_GLOBAL_CTRL_STATUS_REG;
		clrSingle[7] = busRd && busAddr == `DMIP_ADDR_QUAD_ST;
		clrSingle[8] = busRd && busAddr == `DMIP_ADDR_TMRB_ST;
		clrSingle[9] = busRd && busAddr == `DMIP_ADDR_TMRA_ST;
		clrSingle[10] = busRd && busAddr == `DMIP_ADDR_CAP_ST;
		clrSingle[11] = busWr && busAddr[15:2] == 14'(`DMIP_ADDR_PWM >> 2);
	end

	// Clear decode for slave and serial ports
	for (genvar j = 0; j < `DMIP_NDUPLEX; j++) begin : g_duplex
		if (j == 0) begin : g_slave
			assign rxClr[j] = busRd && busAddr[15:2] == 14'(`DMIP_ADDR_SLV_D0 >> 2)
				&& busAddr[1:0] != 2'h3;
			assign txClr[j] = busWr && busAddr[15:2] == 14'(`DMIP_ADDR_SLV_D0 >> 2);
		end else begin : g_serial
			localparam logic [15:0] BASE = 16'(`DMIP_ADDR_SER + (j - 1) * `DMIP_SER_STRIDE);
			assign rxClr[j] = busRd && busAddr[15:2] == BASE[15:2] && !busAddr[1];
			// data, address-data, last or status write
			assign txClr[j] = busWr && busAddr[15:2] == BASE[15:2];
		end
	end

	// Pending flags, a new event beats a clear
	always_comb begin
		flag_next = evtSet | (flag_reg & ~clrSingle);
		rxFlag_next = {evtSerRx, evtSlaveRx} | (rxFlag_reg & ~rxClr);
		txFlag_next = {evtSerTx, evtSlaveTx} | (txFlag_reg & ~txClr);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flag_reg <= 12'h000;
			rxFlag_reg <= 7'h00;
			txFlag_reg <= 7'h00;
		end else begin
			flag_reg <= flag_next;
			rxFlag_reg <= rxFlag_next;
			txFlag_reg <= txFlag_next;
		end
	end

	assign srcReq = {rxFlag_reg | txFlag_reg, flag_reg};

	// Effective level per source
	for (genvar i = 0; i < `DMIP_NSRC; i++) begin : g_lvl
		if (i < `DMIP_NFIXED) begin : g_fixed
			assign effLvl[2*i +: 2] = `DMIP_LVL_TOP;
		end else begin : g_prog
			localparam int P = i - `DMIP_NFIXED;
			assign effLvl[2*i +: 2] =
				(usrCfg_reg[P] && lvlCfg_reg[2*P +: 2] == `DMIP_LVL_TOP)
				? `DMIP_LVL_USER_MAX : lvlCfg_reg[2*P +: 2];
		end
	end

	dmip_prio_sel u_sel (
		.req(srcReq),
		.lvl(effLvl),
		.cpuLevel(cpuLevel),
		.found(selFound),
		.level(selLevel),
		.src(selSrc)
	);

	// Presented request, held off one cycle after acknowledge
	always_comb begin
		irqReq_next = selFound && !takeIrq;
		irqLevel_next = selFound ? selLevel : 2'h0;
		irqSrc_next = selSrc;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irqReq_reg <= 1'b0;
			irqLevel_reg <= 2'h0;
			irqSrc_reg <= dmip_pkg::SRC_MODE_VIOL;
		end else begin
			irqReq_reg <= irqReq_next;
			irqLevel_reg <= irqLevel_next;
			irqSrc_reg <= irqSrc_next;
		end
	end

	// Configuration register writes
	always_comb begin
		lvlCfg_next = lvlCfg_reg;
		usrCfg_next = usrCfg_reg;
		dualEn_next = dualEn_reg;
		if (busWr) begin
			case (busAddr)
				`DMIP_ADDR_LVL0: lvlCfg_next[7:0] = busWdata;
				`DMIP_ADDR_LVL1: lvlCfg_next[15:8] = busWdata;
				`DMIP_ADDR_LVL2: lvlCfg_next[23:16] = busWdata;
				`DMIP_ADDR_LVL3: lvlCfg_next[29:24] = busWdata[5:0];
				`DMIP_ADDR_USR0: usrCfg_next[7:0] = busWdata;
				`DMIP_ADDR_USR1: usrCfg_next[14:8] = busWdata[6:0];
				`DMIP_ADDR_DUAL: dualEn_next = busWdata[`DMIP_DUAL_EN_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lvlCfg_reg <= 30'h00000000;
			usrCfg_reg <= 15'h0000;
			dualEn_reg <= 1'b0;
		end else begin
			lvlCfg_reg <= lvlCfg_next;
			usrCfg_reg <= usrCfg_next;
			dualEn_reg <= dualEn_next;
		end
	end

	// Read mux, data valid only in the cycle after the strobe
	always_comb begin
		case (busAddr)
			`DMIP_ADDR_LVL0: readVal = lvlCfg_reg[7:0];
			`DMIP_ADDR_LVL1: readVal = lvlCfg_reg[15:8];
			`DMIP_ADDR_LVL2: readVal = lvlCfg_reg[23:16];
			`DMIP_ADDR_LVL3: readVal = {2'h0, lvlCfg_reg[29:24]};
			`DMIP_ADDR_USR0: readVal = usrCfg_reg[7:0];
			`DMIP_ADDR_USR1: readVal = {1'b0, usrCfg_reg[14:8]};
			`DMIP_ADDR_DUAL: readVal = {7'h00, dualEn_reg};
			`DMIP_ADDR_PEND0: readVal = srcReq[7:0];
			`DMIP_ADDR_PEND1: readVal = srcReq[15:8];
			`DMIP_ADDR_PEND2: readVal = {5'h00, srcReq[18:16]};
			`DMIP_ADDR_MODE: readVal = modeStackQ;
			default: readVal = 8'h00;
		endcase
		rdata_next = busRd ? readVal : 8'h00;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	assign busRdata = rdata_reg;
	assign irqReq = irqReq_reg;
	assign irqLevel = irqLevel_reg;
	assign irqSrc = irqSrc_reg;
	assign userMode = modeStackQ[0];
	assign modeStack = modeStackQ;

	// Checker helpers
	logic selUser, beaten;
	assign selUser = selSrc >= dmip_pkg::SRC_EXT1 && usrCfg_reg[4'(selSrc - 5'h04)];
	always_comb begin
		beaten = 1'b0;
		for (int k = 0; k < `DMIP_NSRC; k++) begin
			if (srcReq[k] && effLvl[2*k +: 2] > cpuLevel) begin
				if (effLvl[2*k +: 2] > selLevel) begin
					beaten = 1'b1;
				end
				if (effLvl[2*k +: 2] == selLevel && k < int'(selSrc)) begin
					beaten = 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_user_detect;
		modeDetectInstr && dualEn_reg && userMode;
	endsequence
	sequence s_priv_detect;
		modeDetectInstr && !userMode && !flag_reg[0];
	endsequence
	sequence s_wdog_idle;
		!(busWr && busAddr == `DMIP_ADDR_WDOG);
	endsequence

	chk_user_cap:
	assert property (selFound && selUser && !takeIrq |=> irqReq && irqLevel != 2'h3)
		else $error("user source presented at top level");
	chk_user_demote:
	assert property (usrCfg_reg[0] && lvlCfg_reg[1:0] == 2'h3 && selFound
		&& selSrc == dmip_pkg::SRC_EXT1 && !takeIrq |=> irqLevel == 2'h2)
		else $error("user top level not demoted");
	chk_fixed_top:
	assert property (selFound && selSrc < dmip_pkg::SRC_EXT1 && !takeIrq
		|=> irqReq && irqLevel == 2'h3)
		else $error("protection source not at top");
	chk_rank_order:
	assert property (selFound |-> !beaten) else $error("wrong source selected");
	chk_ack_clear:
	assert property ((|ackClr) && !(|(ackClr & evtSet)) |=> !(|(flag_reg & $past(ackClr))))
		else $error("acknowledge did not clear");
	chk_wdog_hold:
	assert property (flag_reg[3] ##0 s_wdog_idle [*2] |=> flag_reg[3])
		else $error("watchdog request dropped");
	chk_periodic_clr:
	assert property (busRd && busAddr == `DMIP_ADDR_GLOBAL_CTRL_STATUS_REG && !perTick_reg |=> !flag_reg[6])
		else $error("global status read did not clear");
	chk_tick_space:
	assert property (perTick_reg |=> !perTick_reg [*8]) else $error("periodic too fast");
	chk_status_clr:
	assert property (busRd && busAddr == `DMIP_ADDR_TMRA_ST && !evtTimerA |=> !flag_reg[9])
		else $error("timer status read did not clear");
	chk_slave_clr:
	assert property (busWr && busAddr == `DMIP_ADDR_SLV_ST && !evtSlaveTx |=> !txFlag_reg[0])
		else $error("slave status write did not clear");
	chk_serial_rx:
	assert property (busRd && busAddr == (`DMIP_ADDR_SER + `DMIP_SER_ADDR_DATA)
		&& !evtSerRx[0] |=> !rxFlag_reg[1])
		else $error("serial receive not cleared");
	chk_serial_tx:
	assert property (busWr && busAddr == (`DMIP_ADDR_SER + `DMIP_SER_LAST)
		&& !evtSerTx[0] |=> !txFlag_reg[1])
		else $error("serial transmit not cleared");
	chk_detect_user:
	assert property (s_user_detect |=> flag_reg[0] && srcReq[0])
		else $error("mode detect did not flag");
	chk_detect_priv:
	assert property (s_priv_detect |=> !flag_reg[0]) else $error("mode detect flagged");
	chk_ack_gap:
	assert property (takeIrq |=> !irqReq && !userMode) else $error("entry not privileged");
endmodule
`default_nettype wire

//--- verilog/dmip_map.svh
// Addresses, field positions, reset values and timing counts for the interrupt block
`ifndef DMIP_MAP_SVH
`define DMIP_MAP_SVH
`define DMIP_NSRC 19
`define DMIP_NSINGLE 12
`define DMIP_NDUPLEX 7
`define DMIP_NFIXED 4
`define DMIP_NPROG 15
`define DMIP_ACK_CLR_MASK 12'h037
`define DMIP_LVL_TOP 2'h3
`define DMIP_LVL_USER_MAX 2'h2
`define DMIP_PRIV_CODE 2'h0
`define DMIP_USER_CODE 2'h1
`define DMIP_MODE_RESET 8'h00
`define DMIP_DUAL_EN_BIT 0
`define DMIP_ADDR_GLOBAL_CTRL_STATUS_REG 16'h0000
`define DMIP_ADDR_WDOG 16'h0008
`define DMIP_ADDR_SLV_D0 16'h0020
`define DMIP_ADDR_SLV_ST 16'h0023
`define DMIP_ADDR_DUAL 16'h0420
`define DMIP_ADDR_QUAD_ST 16'h0500
`define DMIP_ADDR_TMRB_ST 16'h0501
`define DMIP_ADDR_TMRA_ST 16'h0502
`define DMIP_ADDR_CAP_ST 16'h0503
`define DMIP_ADDR_PWM 16'h0508
`define DMIP_ADDR_SER 16'h0510
`define DMIP_SER_STRIDE 16'h0010
`define DMIP_SER_ADDR_DATA 16'h0001
`define DMIP_SER_LAST 16'h0002
`define DMIP_ADDR_LVL0 16'h0600
`define DMIP_ADDR_LVL1 16'h0601
`define DMIP_ADDR_LVL2 16'h0602
`define DMIP_ADDR_LVL3 16'h0603
`define DMIP_ADDR_USR0 16'h0604
`define DMIP_ADDR_USR1 16'h0605
`define DMIP_ADDR_PEND0 16'h0608
`define DMIP_ADDR_PEND1 16'h0609
`define DMIP_ADDR_PEND2 16'h060A
`define DMIP_ADDR_MODE 16'h060B
`define DMIP_CLK_HZ 20000000
`define DMIP_PERIODIC_HZ 2000
`define DMIP_PERIOD_CYCLES (`DMIP_CLK_HZ / `DMIP_PERIODIC_HZ)
`endif

//--- verilog/dmip_pkg.sv
// Types shared by the interrupt priority block
`default_nettype none
package dmip_pkg;
	typedef logic [1:0] dmip_level_t;
	typedef enum logic [4:0] {
		SRC_MODE_VIOL, SRC_STACK, SRC_WPROT, SRC_SWDOG, SRC_EXT1, SRC_EXT0,
		SRC_PERIODIC, SRC_QUAD, SRC_TMRB, SRC_TMRA, SRC_CAPTURE, SRC_PWM,
		SRC_SLAVE, SRC_SER_E, SRC_SER_F, SRC_SER_A, SRC_SER_B, SRC_SER_C, SRC_SER_D
	} dmip_src_t;
endpackage
`default_nettype wire

//--- verilog/dmip_prio_sel.sv
// Fixed-order priority selector over all interrupt sources
`timescale 1ns/1ns
`default_nettype none
`include "dmip_map.svh"
module dmip_prio_sel (
	input wire logic [`DMIP_NSRC-1:0] req, // Pending per source
	input wire logic [2*`DMIP_NSRC-1:0] lvl, // Effective level per source
	input wire logic [1:0] cpuLevel, // Level the core runs at
	output logic found, // A request beats the core level
	output dmip_pkg::dmip_level_t level, // Winning level
	output dmip_pkg::dmip_src_t src // Winning source
);
	// Highest level wins, lower index wins a tie
	always_comb begin
		found = 1'b0;
		level = 2'h0;
		src = dmip_pkg::SRC_MODE_VIOL;
		for (int i = `DMIP_NSRC - 1; i >= 0; i--) begin
			if (req[i] && lvl[2*i +: 2] > cpuLevel && lvl[2*i +: 2] >= level) begin
				found = 1'b1;
				level = lvl[2*i +: 2];
				src = dmip_pkg::dmip_src_t'(i[4:0]);
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/dmip_mode_stack.sv
// Privileged/unprivileged mode stack register
`timescale 1ns/1ns
`default_nettype none
`include "dmip_map.svh"
module dmip_mode_stack (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Async reset, low
	input wire logic enter, // Interrupt, restart or system call
	input wire logic setUser, // Enter unprivileged mode
	input wire logic restore, // Return to previous mode
	output logic [7:0] modeStack // Stack, current mode in low bits
);
	logic [7:0] stack_reg;
	logic [7:0] stack_next;

	// Entry wins over set and restore
	always_comb begin
		stack_next = stack_reg;
		if (enter) begin
			stack_next = {stack_reg[5:0], `DMIP_PRIV_CODE};
		end else if (setUser) begin
			stack_next = {stack_reg[5:0], `DMIP_USER_CODE};
		end else if (restore) begin
			stack_next = {stack_reg[1:0], stack_reg[7:2]};
		end
	end

	// Stack register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stack_reg <= `DMIP_MODE_RESET;
		end else begin
			stack_reg <= stack_next;
		end
	end

	assign modeStack = stack_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	chk_entry_priv:
	assert property (enter |=> !stack_reg[0]) else $error("entry left user mode");
	chk_entry_push:
	assert property (enter |=> stack_reg == {$past(stack_reg[5:0]), 2'h0})
		else $error("entry push wrong");
	chk_restore_rot:
	assert property (restore && !enter && !setUser
		|=> stack_reg == {$past(stack_reg[1:0]), $past(stack_reg[7:2])})
		else $error("restore rotate wrong");
endmodule
`default_nettype wire

//--- dv/dmip_core_model.sv
// Behavioural core that acknowledges presented interrupt requests
`timescale 1ns/1ns
`default_nettype none
module dmip_core_model (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Async reset, low
	input wire logic irqReq, // Request from controller
	input wire logic ackArm, // Bench allows an acknowledge
	input wire logic [1:0] ackDelay, // Cycles to wait before acking
	output logic intAck // Acknowledge pulse
);
	logic [1:0] waitCnt_reg;
	logic [1:0] waitCnt_next;
	logic intAck_reg;
	logic intAck_next;
	// Wait a set time on a pending request, then ack once; never two acks in a row
	always_comb begin
		waitCnt_next = 2'h0;
		intAck_next = 1'b0;
		if (ackArm && irqReq && !intAck_reg) begin
			if (waitCnt_reg == ackDelay) begin
				intAck_next = 1'b1;
			end else begin
				waitCnt_next = waitCnt_reg + 2'h1;
			end
		end
	end
	// Register counter and pulse
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			waitCnt_reg <= 2'h0;
			intAck_reg <= 1'b0;
		end else begin
			waitCnt_reg <= waitCnt_next;
			intAck_reg <= intAck_next;
		end
	end
	assign intAck = intAck_reg;
endmodule
`default_nettype wire

//--- dv/tb_dual_mode_interrupt_priority.sv
// Self-checking testbench for the dual-mode interrupt priority controller
`timescale 1ns/1ns
`default_nettype none
module tb_dual_mode_interrupt_priority;
	localparam int PER = 20;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic [7:0] busWdata = 8'h00;
	logic busWr = 1'b0;
	logic busRd = 1'b0;
	logic [7:0] busRdata;
	logic [11:0] evt = 12'h000; // Stack..slave tx, in port order
	logic [5:0] serRx = 6'h00;
	logic [5:0] serTx = 6'h00;
	logic [1:0] cpuLevel = 2'h0;
	logic [4:0] instr = 5'h00; // Restart, system_call_instr, setUser, restore, detect
	logic ackArm = 1'b0;
	logic [1:0] ackDelay = 2'h0;
	logic intAck;
	logic irqReq;
	logic userMode;
	logic [7:0] modeStack;
	dmip_pkg::dmip_level_t irqLevel;
	dmip_pkg::dmip_src_t irqSrc;
	int mismatches = 0;
	int checkCount = 0;

	// Clock, 50 ns period
	always #25 mclk = ~mclk;

	dmip_ctrl #(.PERIOD_CYCLES(PER)) uut (.mclk(mclk), .rst_b(rst_b), .busAddr(busAddr),
		.busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
		.evtStackLimit(evt[0]), .evtWriteProt(evt[1]), .evtSecWatchdog(evt[2]),
		.evtExt1(evt[3]), .evtExt0(evt[4]), .evtQuad(evt[5]), .evtTimerB(evt[6]),
		.evtTimerA(evt[7]), .evtCapture(evt[8]), .evtPwm(evt[9]), .evtSlaveRx(evt[10]),
		.evtSlaveTx(evt[11]), .evtSerRx(serRx), .evtSerTx(serTx), .cpuLevel(cpuLevel),
		.intAck(intAck), .restartInstr(instr[0]), .sysCallInstr(instr[1]),
		.setUserInstr(instr[2]), .modeRestoreInstr(instr[3]), .modeDetectInstr(instr[4]),
		.irqReq(irqReq), .irqLevel(irqLevel), .irqSrc(irqSrc), .userMode(userMode),
		.modeStack(modeStack));

	dmip_core_model core (.mclk(mclk), .rst_b(rst_b), .irqReq(irqReq), .ackArm(ackArm),
		.ackDelay(ackDelay), .intAck(intAck));

	task automatic giveVerdict();
		if (mismatches == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bail(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			giveVerdict();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Bus cycles: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		busWr <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		@(posedge mclk);
		busWr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge mclk);
		busRd <= 1'b0;
		#1;
		d = busRdata;
	endtask
	task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// One-cycle event and instruction pulses
	task automatic fire(input logic [11:0] e, input logic [5:0] rx, input logic [5:0] tx,
		input logic [4:0] ins);
		@(posedge mclk);
		evt <= e;
		serRx <= rx;
		serTx <= tx;
		instr <= ins;
		@(posedge mclk);
		evt <= 12'h000;
		serRx <= 6'h00;
		serTx <= 6'h00;
		instr <= 5'h00;
		cyc(1);
	endtask
	task automatic expectIrq(input dmip_pkg::dmip_src_t s, input logic [1:0] l);
		int n;
		n = 0;
		while (irqReq !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		bail(n, 50);
		chk(8'(irqSrc), 8'(s));
		chk({6'h00, irqLevel}, {6'h00, l});
	endtask
	task automatic ack(input logic [1:0] dly);
		int n;
		n = 0;
		@(posedge mclk);
		ackDelay <= dly;
		ackArm <= 1'b1;
		while (intAck !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		bail(n, 20);
		@(posedge mclk);
		ackArm <= 1'b0;
		cyc(3);
	endtask

	task automatic scReset();
		chk({7'h00, irqReq}, 8'h00);
		rdChk(16'h060B, 8'h00);
		rdChk(16'h0608, 8'h00);
		rdChk(16'h0777, 8'h00);
	endtask
	// Fixed top-level sources, masking by core level, ack and watchdog clears
	task automatic scFixed();
		@(posedge mclk);
		cpuLevel <= 2'h3;
		fire(12'h007, 6'h00, 6'h00, 5'h00);
		cyc(3);
		chk({7'h00, irqReq}, 8'h00);
		@(posedge mclk);
		cpuLevel <= 2'h2;
		cyc(1);
		expectIrq(dmip_pkg::SRC_STACK, 2'h3);
		ack(2'h0);
		expectIrq(dmip_pkg::SRC_WPROT, 2'h3);
		ack(2'h2);
		expectIrq(dmip_pkg::SRC_SWDOG, 2'h3);
		ack(2'h1);
		expectIrq(dmip_pkg::SRC_SWDOG, 2'h3);
		wr(16'h0008, 8'h00);
		cyc(3);
		chk({7'h00, irqReq}, 8'h00);
		@(posedge mclk);
		cpuLevel <= 2'h0;
	endtask
	// User-assigned source capped below the top level
	task automatic scUserCap();
		wr(16'h0604, 8'h01);
		for (int l = 1; l < 4; l++) begin
			wr(16'h0600, 8'(l));
			fire(12'h008, 6'h00, 6'h00, 5'h00);
			expectIrq(dmip_pkg::SRC_EXT1, (l == 3) ? 2'h2 : 2'(l));
			ack(2'(l));
		end
		wr(16'h0604, 8'h00);
		fire(12'h008, 6'h00, 6'h00, 5'h00);
		expectIrq(dmip_pkg::SRC_EXT1, 2'h3);
		ack(2'h0);
		chk({7'h00, irqReq}, 8'h00);
	endtask
	// All programmable sources except periodic at one level, served in order, each by its own clear
	task automatic scOrder();
		logic [7:0] d;
		wr(16'h0600, 8'h45);
		wr(16'h0601, 8'h55);
		wr(16'h0602, 8'h55);
		wr(16'h0603, 8'h15);
		fire(12'h7F8, 6'h3F, 6'h00, 5'h00);
		rdChk(16'h0601, 8'h55);
		rdChk(16'h0609, 8'hFF);
		rdChk(16'h060A, 8'h07);
		for (int k = 4; k < 19; k++) begin
			if (k != 6) begin
				expectIrq(dmip_pkg::dmip_src_t'(k), 2'h1);
				if (k < 6) ack(2'h0);
				else if (k < 11) rd(16'h04F9 + 16'(k), d);
				else if (k == 11) wr(16'h0509, 8'hA5);
				else if (k == 12) rd(16'h0021, d);
				else rd(16'h0510 + 16'((k - 13) * 16 + k % 2), d);
				cyc(3);
			end
		end
		chk({7'h00, irqReq}, 8'h00);
		fire(12'h800, 6'h00, 6'h3F, 5'h00);
		for (int k = 12; k < 19; k++) begin
			expectIrq(dmip_pkg::dmip_src_t'(k), 2'h1);
			if (k == 12) wr(16'h0023, 8'h00);
			else wr(16'h0510 + 16'((k - 13) * 16 + (k - 11) % 4), 8'h00);
			cyc(3);
		end
		chk({7'h00, irqReq}, 8'h00);
	endtask
	// Periodic request recurs and is cleared by the global status read
	task automatic scPeriodic();
		logic [7:0] d;
		wr(16'h0600, 8'h10);
		rd(16'h0000, d);
		cyc(3);
		expectIrq(dmip_pkg::SRC_PERIODIC, 2'h1);
		rd(16'h0000, d);
		cyc(3);
		chk({7'h00, irqReq}, 8'h00);
		expectIrq(dmip_pkg::SRC_PERIODIC, 2'h1);
		wr(16'h0600, 8'h00);
	endtask
	// Mode stack entry, restore and mode-detect violation
	task automatic scMode();
		wr(16'h0420, 8'h01);
		rdChk(16'h0420, 8'h01);
		fire(12'h000, 6'h00, 6'h00, 5'h04);
		chk(modeStack, 8'h01);
		fire(12'h000, 6'h00, 6'h00, 5'h10);
		expectIrq(dmip_pkg::SRC_MODE_VIOL, 2'h3);
		ack(2'h1);
		chk(modeStack, 8'h04);
		chk({7'h00, userMode}, 8'h00);
		fire(12'h000, 6'h00, 6'h00, 5'h08);
		chk(modeStack, 8'h01);
		fire(12'h000, 6'h00, 6'h00, 5'h02);
		chk(modeStack, 8'h04);
		fire(12'h000, 6'h00, 6'h00, 5'h08);
		fire(12'h000, 6'h00, 6'h00, 5'h01);
		chk(modeStack, 8'h04);
		fire(12'h000, 6'h00, 6'h00, 5'h08);
		fire(12'h000, 6'h00, 6'h00, 5'h08);
		chk(modeStack, 8'h40);
		fire(12'h000, 6'h00, 6'h00, 5'h10);
		cyc(3);
		chk({7'h00, irqReq}, 8'h00);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		cyc(1);
		scReset();
		scFixed();
		scUserCap();
		scOrder();
		scPeriodic();
		scMode();
		giveVerdict();
	end
endmodule
`default_nettype wire
